// ===== rtl/ffa_top.v
// Flash fetch accelerator: latches, prefetch, fetch timing and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "ffa_defines.vh"
module ffa_top (
  input  wire         core_clk,
  input  wire         reset,
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [31:0]  wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output reg          wb_ack_o,
  input  wire         cpu_req,
  input  wire         cpu_instr,
  input  wire         cpu_seq,
  input  wire [16:0]  cpu_addr,
  output reg  [31:0]  cpu_rdata,
  output reg          cpu_rvalid,
  output wire         cpu_clock_gate,
  input  wire         flash_busy,
  input  wire         flash_prog_start,
  output reg          flash_rd_en,
  output reg  [12:0]  flash_rd_line,
  input  wire [127:0] flash_rdata
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_MIMIC = 2'h2;
  localparam [1:0] ST_PREF  = 2'h3;

  reg [1:0]                  mode_ff;
  reg [2:0]                  tim_ff;
  reg [1:0]                  state_ff;
  reg [2:0]                  cnt_ff;
  reg                        instr_ff;
  reg [1:0]                  word_ff;
  reg [31:0]                 hold_ff;
  reg                        pf_pend_ff;
  reg                        drop_ff;
  reg [12:0]                 pf_line_ff;
  reg [1:0]                  pb_v_ff;
  reg [1:0]                  bt_v_ff;
  reg [`FFA_TAG_W-1:0]       pb_tag_ff [0:1];
  reg [`FFA_TAG_W-1:0]       bt_tag_ff [0:1];
  reg [`FFA_LINE_W-1:0]      pb_data_ff [0:1];
  reg [`FFA_LINE_W-1:0]      bt_data_ff [0:1];
  reg                        dl_v_ff;
  reg [`FFA_LINE_IDX_W-1:0]  dl_tag_ff;
  reg [`FFA_LINE_W-1:0]      dl_data_ff;

  wire [12:0]            req_line = cpu_addr[16:4];
  wire                   req_bank = req_line[0];
  wire [`FFA_TAG_W-1:0]  req_tag  = req_line[12:1];
  wire [1:0]             req_word = cpu_addr[3:2];
  wire                   fl_bank  = flash_rd_line[0];
  wire [`FFA_TAG_W-1:0]  fl_tag   = flash_rd_line[12:1];

  // Per bank comparison of the request against both code lines
  wire [1:0] pb_hit;
  wire [1:0] bt_hit;
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : gen_bank
      assign pb_hit[b] = pb_v_ff[b] && (pb_tag_ff[b] == req_tag);
      assign bt_hit[b] = bt_v_ff[b] && (bt_tag_ff[b] == req_tag);
    end
  endgenerate

  wire ihit_pb = pb_hit[req_bank];
  wire ihit_bt = bt_hit[req_bank];
  wire dhit    = dl_v_ff && (dl_tag_ff == req_line);
  wire latched = cpu_instr ? (ihit_pb | ihit_bt) : dhit;
  wire [`FFA_LINE_W-1:0] hit_line = !cpu_instr ? dl_data_ff :
                                    ihit_bt ? bt_data_ff[req_bank] : pb_data_ff[req_bank];

  // Reserved mode 11 behaves as off
  // mode decode
  wire mode_part = (mode_ff == `FFA_MODE_PART);
  wire mode_full = (mode_ff == `FFA_MODE_FULL);
  wire pf_en     = mode_part | mode_full;
  wire fast      = latched && (mode_full || (mode_part && cpu_instr && cpu_seq));

  // reserved zero runs as one clock
  wire [2:0] eff_tim = (tim_ff == 3'h0) ? `FFA_TIM_ONE : tim_ff;

  function [31:0] pick_word;
    input [127:0] line;
    input [1:0]   idx;
    begin
      case (idx)
        2'h0:    pick_word = line[31:0];
        2'h1:    pick_word = line[63:32];
        2'h2:    pick_word = line[95:64];
        default: pick_word = line[127:96];
      endcase
    end
  endfunction

  wire req_live = cpu_req && !cpu_rvalid;
  assign cpu_clock_gate = !req_live;

  // Wishbone decode
  // word-aligned register decode
  wire bus_req  = wb_cyc_i && wb_stb_i;
  wire sel_mode = (wb_adr_i == `FFA_ADDR_MODE);
  wire sel_tim  = (wb_adr_i == `FFA_ADDR_TIMING);
  wire sel_stat = (wb_adr_i == `FFA_ADDR_STATUS);
  wire wr_take  = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire wr_mode  = wr_take && sel_mode;
  wire wr_tim   = wr_take && sel_tim;
  wire mode_chg = wr_mode && (wb_dat_i[`FFA_MODE_MSB:`FFA_MODE_LSB] != mode_ff);
  wire inv      = flash_prog_start | mode_chg;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (sel_mode) begin
      rd_mux[`FFA_MODE_MSB:`FFA_MODE_LSB] = mode_ff;
    end else if (sel_tim) begin
      rd_mux[`FFA_TIM_MSB:`FFA_TIM_LSB] = tim_ff;
    end else if (sel_stat) begin
      rd_mux[1:0] = state_ff;
      rd_mux[2]   = pf_pend_ff;
      rd_mux[3]   = flash_busy;
      rd_mux[5:4] = bt_v_ff;
      rd_mux[7:6] = pb_v_ff;
      rd_mux[8]   = dl_v_ff;
    end
  end

  // Bus slave: answer one cycle after the request, write at the ack edge
  always @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      mode_ff  <= `FFA_MODE_RST;
      tim_ff   <= `FFA_TIM_RST;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
      if (wr_mode) begin
        mode_ff <= wb_dat_i[`FFA_MODE_MSB:`FFA_MODE_LSB];
      end
      if (wr_tim) begin
        tim_ff <= wb_dat_i[`FFA_TIM_MSB:`FFA_TIM_LSB];
      end
    end
  end

  // Access sequencer and latch storage
  always @(posedge core_clk) begin
    if (reset) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= 3'h0;
      instr_ff      <= 1'b0;
      word_ff       <= 2'h0;
      hold_ff       <= 32'h00000000;
      pf_pend_ff    <= 1'b0;
      pf_line_ff    <= 13'h0000;
      drop_ff       <= 1'b0;
      pb_v_ff       <= 2'h0;
      bt_v_ff       <= 2'h0;
      pb_tag_ff[0]  <= 12'h000;
      pb_tag_ff[1]  <= 12'h000;
      bt_tag_ff[0]  <= 12'h000;
      bt_tag_ff[1]  <= 12'h000;
      pb_data_ff[0] <= 128'h0;
      pb_data_ff[1] <= 128'h0;
      bt_data_ff[0] <= 128'h0;
      bt_data_ff[1] <= 128'h0;
      dl_v_ff       <= 1'b0;
      dl_tag_ff     <= 13'h0000;
      dl_data_ff    <= 128'h0;
      cpu_rdata     <= 32'h00000000;
      cpu_rvalid    <= 1'b0;
      flash_rd_en   <= 1'b0;
      flash_rd_line <= 13'h0000;
    end else begin
      cpu_rvalid <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (req_live && !flash_busy) begin
            if (fast) begin
              cpu_rdata  <= pick_word(hit_line, req_word);
              cpu_rvalid <= 1'b1;
            // mimic flash stall, skipped at one clock
            end else if (latched && (eff_tim != `FFA_TIM_ONE)) begin
              hold_ff  <= pick_word(hit_line, req_word);
              cnt_ff   <= eff_tim;
              state_ff <= ST_MIMIC;
            end else begin
              flash_rd_line <= req_line;
              instr_ff      <= cpu_instr;
              word_ff       <= req_word;
              cnt_ff        <= eff_tim;
              flash_rd_en   <= 1'b1;
              state_ff      <= ST_FETCH;
              drop_ff       <= 1'b0;
            end
          end else if (!req_live && pf_pend_ff && pf_en && !flash_busy) begin
            flash_rd_line <= pf_line_ff;
            cnt_ff        <= eff_tim;
            flash_rd_en   <= 1'b1;
            pf_pend_ff    <= 1'b0;
            state_ff      <= ST_PREF;
            drop_ff       <= 1'b0;
          end
        end
        ST_MIMIC: begin
          if (cnt_ff == 3'h1) begin
            cpu_rdata  <= hold_ff;
            cpu_rvalid <= 1'b1;
            state_ff   <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        ST_FETCH: begin
          // read cut by program or erase is retried
          if (flash_busy) begin
            flash_rd_en <= 1'b0;
            state_ff    <= ST_IDLE;
          end else if (cnt_ff == 3'h1) begin
            flash_rd_en <= 1'b0;
            cpu_rdata   <= pick_word(flash_rdata, word_ff);
            cpu_rvalid  <= 1'b1;
            state_ff    <= ST_IDLE;
            if (instr_ff) begin
              bt_data_ff[fl_bank] <= flash_rdata;
              bt_tag_ff[fl_bank]  <= fl_tag;
              bt_v_ff[fl_bank]    <= !drop_ff;
              if (pf_en) begin
                pf_pend_ff <= 1'b1;
                pf_line_ff <= flash_rd_line + 13'h0001;
              end
            end else begin
              dl_data_ff <= flash_rdata;
              dl_tag_ff  <= flash_rd_line;
              dl_v_ff    <= !drop_ff;
            end
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        ST_PREF: begin
          // prefetch cut by program or erase is dropped
          if (flash_busy) begin
            flash_rd_en <= 1'b0;
            state_ff    <= ST_IDLE;
          end else if (cnt_ff == 3'h1) begin
            flash_rd_en <= 1'b0;
            state_ff    <= ST_IDLE;
            pb_data_ff[fl_bank] <= flash_rdata;
            pb_tag_ff[fl_bank]  <= fl_tag;
            pb_v_ff[fl_bank]    <= !drop_ff;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        default: begin
          state_ff    <= ST_IDLE;
          flash_rd_en <= 1'b0;
        end
      endcase
      if (inv) begin
        pb_v_ff    <= 2'h0;
        bt_v_ff    <= 2'h0;
        dl_v_ff    <= 1'b0;
        pf_pend_ff <= 1'b0;
        // A read in flight may carry old contents: its fill stays invalid
        drop_ff    <= 1'b1;
      end
    end
  end

endmodule // ffa_top
`default_nettype wire

// ===== include/ffa_defines.vh
// Register map, field positions, reset values and widths of the flash fetch accelerator
`ifndef FFA_DEFINES_VH
`define FFA_DEFINES_VH
`define FFA_ADDR_MODE     32'hE01FC000
`define FFA_ADDR_TIMING   32'hE01FC004
`define FFA_ADDR_STATUS   32'hE01FC008
`define FFA_MODE_MSB      1
`define FFA_MODE_LSB      0
`define FFA_TIM_MSB       2
`define FFA_TIM_LSB       0
`define FFA_MODE_RST      2'h0
`define FFA_TIM_RST       3'h7
`define FFA_MODE_OFF      2'h0
`define FFA_MODE_PART     2'h1
`define FFA_MODE_FULL     2'h2
`define FFA_TIM_ONE       3'h1
`define FFA_LINE_W        128
`define FFA_LINE_IDX_W    13
`define FFA_TAG_W         12
`define FFA_ADDR_W        17
`endif

// ===== tb/ffa_checker.sv
// Port checks for the flash fetch accelerator
`timescale 1ns/1ps
`default_nettype none
module ffa_checker (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        cpu_req,
  input wire logic        cpu_rvalid,
  input wire logic        cpu_clock_gate,
  input wire logic        flash_busy,
  input wire logic        flash_rd_en,
  input wire logic [12:0] flash_rd_line
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_gate_stall: assert property (cpu_req && !cpu_rvalid |-> !cpu_clock_gate)
    else $error("clock gate open while a request waits");
  a_gate_idle: assert property (!cpu_req |-> cpu_clock_gate)
    else $error("processor stalled without a request");
  a_busy_hold: assert property (flash_busy |=> !$rose(flash_rd_en))
    else $error("flash read started while flash busy");
  a_busy_abort: assert property (flash_busy && flash_rd_en |=> !flash_rd_en)
    else $error("flash read kept running while flash busy");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reg_width: assert property (wb_ack_o |-> wb_dat_o[31:9] == 23'h0)
    else $error("unused register bits read nonzero");
  a_rv_pulse: assert property (cpu_rvalid |=> !cpu_rvalid)
    else $error("answer pulse longer than one cycle");
  a_line_stable: assert property (flash_rd_en && $past(flash_rd_en) |-> $stable(flash_rd_line))
    else $error("flash line changed during a read");
  a_fetch_max: assert property ($rose(flash_rd_en) |-> ##[1:7] !flash_rd_en)
    else $error("flash read longer than seven clocks");
  a_reset_quiet: assert property ($past(reset) |-> !cpu_rvalid && !flash_rd_en && !wb_ack_o)
    else $error("outputs active right after reset");
endmodule // ffa_checker
`default_nettype wire

// ===== tb/ffa_flash_model.sv
// Flash array model: each word carries its line and index
`timescale 1ns/1ps
`default_nettype none
module ffa_flash_model (
  input  wire logic [12:0]  flash_rd_line,
  input  wire logic         flash_rd_en,
  output var  logic [127:0] flash_rdata
);
  logic [127:0] pat;
  // Outside a read the bus shows the inverse, never stale data
  always_comb begin
    for (int i = 0; i < 4; i++) pat[32*i +: 32] = {3'h0, flash_rd_line, 14'h0, 2'(i)};
    flash_rdata = flash_rd_en ? pat : ~pat;
  end
endmodule // ffa_flash_model
`default_nettype wire

// ===== tb/flash_fetch_accelerator_test.sv
// Register and processor read scenarios for the flash fetch accelerator
`timescale 1ns/1ps
`default_nettype none
`include "ffa_defines.vh"
module flash_fetch_accelerator_test;
  logic         core_clk = 0, reset = 1, cyc = 0, we = 0, req = 0, instr = 0, seq = 0, busy = 0, pstart = 0;
  logic [31:0]  adr = 0, wdat = 0, rdat, cpu_rdata, wb_dat_o;
  logic [16:0]  caddr = 0;
  logic [12:0]  rd_line;
  logic [127:0] frdata;
  logic         ack, rvalid, gate, rd_en;
  int           num_errors = 0, n_checks = 0, k, m, fl;
  localparam logic [16:0] A = 17'h00120, D = 17'h08040;
  always #4 core_clk = ~core_clk;
  ffa_top dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .cpu_req(req), .cpu_instr(instr),
    .cpu_seq(seq), .cpu_addr(caddr), .cpu_rdata(cpu_rdata), .cpu_rvalid(rvalid), .cpu_clock_gate(gate),
    .flash_busy(busy), .flash_prog_start(pstart), .flash_rd_en(rd_en), .flash_rd_line(rd_line),
    .flash_rdata(frdata));
  ffa_flash_model flash (.flash_rd_line(rd_line), .flash_rd_en(rd_en), .flash_rdata(frdata));
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, d, exp);
    cyc <= 1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin @(posedge core_clk); k++; end while (ack !== 1'b1 && k < 50);
    rdat = wb_dat_o;
    cyc <= 0; we <= 0;
    if (k >= 50) begin num_errors++; end_sim; end
    @(posedge core_clk);
    if (!w) chk(rdat, exp);
  endtask
  // Processor read; n is the answer delay in clocks, fl counts flash read clocks
  task automatic rd(input logic i, s, input logic [16:0] a, input int n);
    req <= 1; instr <= i; seq <= s; caddr <= a;
    k = 0;
    fl = 0;
    do begin @(posedge core_clk); k++; fl += rd_en; end while (rvalid !== 1'b1 && k < 50);
    rdat = cpu_rdata;
    req <= 0;
    if (k >= 50) begin num_errors++; end_sim; end
    chk(rdat, {3'h0, a[16:4], 14'h0, a[3:2]});
    chk(32'(k - 1), 32'(n));
    repeat (10) @(posedge core_clk);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    wb(0, `FFA_ADDR_MODE, 0, 0);
    wb(0, `FFA_ADDR_TIMING, 0, 7);
    wb(0, 32'hE01FC00C, 0, 0);
    wb(1, `FFA_ADDR_TIMING, 3, 0);
    for (m = 0; m < 4; m++) begin
      wb(1, `FFA_ADDR_MODE, m, 0);
      wb(0, `FFA_ADDR_MODE, 0, m);
      rd(1, 0, A, 4);
      rd(1, 0, A, (m == 2) ? 1 : 4);
      chk(fl, 0);
    end
    wb(1, `FFA_ADDR_MODE, 1, 0);
    rd(1, 0, A, 4);
    rd(1, 1, A + 17'h4, 1);
    rd(1, 1, A + 17'h10, 1);
    rd(0, 0, D, 4);
    rd(0, 1, D + 17'h4, 4);
    wb(1, `FFA_ADDR_MODE, 2, 0);
    rd(0, 0, D, 4);
    rd(0, 0, D + 17'h8, 1);
    rd(1, 0, A, 4);
    busy <= 1;
    pstart <= 1;
    fork
      begin repeat (6) @(posedge core_clk); busy <= 0; end
    join_none
    @(posedge core_clk);
    pstart <= 0;
    rd(1, 0, A, 9);
    fork
      begin
        repeat (2) @(posedge core_clk);
        busy <= 1;
        repeat (3) @(posedge core_clk);
        busy <= 0;
      end
    join_none
    rd(0, 0, D + 17'h10, 9);
    wb(1, `FFA_ADDR_MODE, 0, 0);
    wb(1, `FFA_ADDR_TIMING, 1, 0);
    wb(1, `FFA_ADDR_MODE, 1, 0);
    rd(1, 0, A, 2);
    rd(1, 0, A, 2);
    chk(fl, 1);
    reset <= 1;
    repeat (3) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    wb(0, `FFA_ADDR_MODE, 0, 0);
    wb(0, `FFA_ADDR_TIMING, 0, 7);
    rd(1, 0, A, 8);
    rd(1, 0, A, 8);
    chk(fl, 0);
    end_sim;
  end
endmodule // flash_fetch_accelerator_test
bind ffa_top ffa_checker chk_i (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req(cpu_req), .cpu_rvalid(cpu_rvalid),
  .cpu_clock_gate(cpu_clock_gate), .flash_busy(flash_busy), .flash_rd_en(flash_rd_en),
  .flash_rd_line(flash_rd_line));
`default_nettype wire
